/* core/sdc_pkg.sv */
// Shared constants and types for the stereo digital I/O and cascade block
package sdc_pkg;
  localparam int          SAMPLE_W     = 24;                  // Internal sample width
  localparam logic [4:0]  WL_MIN       = 5'h10;               // Shortest output wordlength, 16 bits
  localparam logic [4:0]  WL_MAX       = 5'h18;               // Full wordlength, no reduction
  localparam logic [4:0]  WL_RESET     = 5'h18;               // Wordlength after reset
  localparam int          CLK_HZ       = 200_000_000;         // Core clock rate
  localparam int          FS_HZ        = 44_100;              // Internal sample rate
  localparam int          FS_DIV_CYC   = CLK_HZ / FS_HZ;      // Core cycles per internal sample
  localparam int          GAP_SAMPLES  = 2;                   // Missing samples before lock is lost
  localparam logic [4:0]  TAP_NONE     = 5'h00;               // Stand-alone unit
  localparam logic [4:0]  TAP_LAST     = 5'h0E;               // Last unit, 14 samples
  localparam logic [4:0]  TAP_MIDDLE   = 5'h1C;               // Middle unit, 28 samples
  localparam int          DLY_DEPTH    = 28;                  // Longest channel delay in samples
  localparam logic [3:0]  LOCK_STROBES = 4'h8;                // Clean samples needed to declare lock
  localparam logic signed [15:0] DE_B0 = 16'sh3ADE;           // De-emphasis feed-forward, Q15
  localparam logic signed [15:0] DE_B1 = -16'sh11F9;          // De-emphasis delayed feed-forward, Q15
  localparam logic signed [15:0] DE_A1 = 16'sh571B;           // De-emphasis feedback, Q15
  localparam logic [23:0] LFSR_TAPS    = 24'hE10000;          // Galois taps for the dither source
  localparam logic [23:0] LFSR_SEED    = 24'h000001;          // Dither source value after reset

  // Stereo sample pair
  typedef struct packed {
    logic signed [SAMPLE_W-1:0] left;
    logic signed [SAMPLE_W-1:0] right;
  } sdc_stereo_t;

  // Position of this unit in a cascade chain
  typedef enum logic [1:0] {STG_SOLO, STG_LAST, STG_MIDDLE} sdc_stage_t;

  // Sample clock lock tracking
  typedef enum logic [1:0] {LK_INT, LK_ACQ, LK_LOCKED, LK_LOST} sdc_lock_t;
endpackage

/* core/sdc_sample_delay.sv */
// Stereo sample delay line with selectable tap, used to align cascaded units
`timescale 1ns/1ps
`default_nettype none
module sdc_sample_delay #(
  parameter int DEPTH = sdc_pkg::DLY_DEPTH                    // Longest delay in samples
) (
  input  wire logic                core_clk,                  // Core clock
  input  wire logic                reset_n,                   // Async reset, active low
  input  wire logic                sample_en,                 // One pulse per sample
  input  wire sdc_pkg::sdc_stereo_t din,                      // Sample entering the line
  input  wire logic [4:0]          tap,                       // Delay in samples, 0 to DEPTH
  output sdc_pkg::sdc_stereo_t     dout                       // Delayed sample, registered
);
  import sdc_pkg::*;
  localparam int AW = $clog2(DEPTH);

  sdc_stereo_t         mem [DEPTH];                           // Circular sample store
  logic [AW-1:0]       wptr_reg, wptr_next;                   // Next slot to write
  logic [AW-1:0]       rd_idx;                                // Slot written tap samples ago
  sdc_stereo_t         dout_reg, dout_next;                   // Output register

  // Pointer wrap and tap read; a tap beyond depth is clamped so the line never aliases
  always_comb begin
    logic [AW:0] t;
    t = (tap > 5'(DEPTH)) ? (AW+1)'(DEPTH) : (AW+1)'(tap);
    if ({1'b0, wptr_reg} >= t) begin
      rd_idx = AW'({1'b0, wptr_reg} - t);
    end else begin
      rd_idx = AW'({1'b0, wptr_reg} + (AW+1)'(DEPTH) - t);
    end
    wptr_next = wptr_reg;
    dout_next = dout_reg;
    if (sample_en) begin
      wptr_next = (wptr_reg == AW'(DEPTH - 1)) ? '0 : wptr_reg + 1'b1;
      dout_next = (t == '0) ? din : mem[rd_idx];
    end
  end

  // Storage has no reset; old contents only reach the output during the first DEPTH samples
  always_ff @(posedge core_clk) begin
    if (sample_en) begin
      mem[wptr_reg] <= din;
    end
  end

  // Pointer and output registers
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      wptr_reg <= '0;
      dout_reg <= '0;
    end else begin
      wptr_reg <= wptr_next;
      dout_reg <= dout_next;
    end
  end

  assign dout = dout_reg;

  // Zero tap passes the entering sample straight through
  zero_tap_a: assert property (@(posedge core_clk) disable iff (!reset_n)
    sample_en && tap == 5'h00 |=> dout == $past(din))
    else $error("zero tap did not pass the sample through");
endmodule
`default_nettype wire

/* core/sdc_stereo_io.sv */
// Stereo digital output with dither, stereo input routing, de-emphasis, cascade delay and clock lock
`timescale 1ns/1ps
`default_nettype none
module sdc_stereo_io #(
  parameter int INT_DIV   = sdc_pkg::FS_DIV_CYC,                      // Core cycles per internal sample
  parameter int GAP_LIMIT = sdc_pkg::FS_DIV_CYC * sdc_pkg::GAP_SAMPLES // Silent cycles before lock loss
) (
  input  wire logic                core_clk,                  // Core clock, 200 MHz
  input  wire logic                reset_n,                   // Async reset, active low
  input  wire logic                stereo_input_clock_source, // 1 follows stereo input, 0 internal
  input  wire sdc_pkg::sdc_stereo_t mix_in,                   // Stereo mix to transmit
  input  wire sdc_pkg::sdc_stereo_t slot_mix_in,              // Mix pair for the slot outputs
  input  wire logic [4:0]          stereo_out_wordlength,     // Stereo output wordlength, 16 to 24
  input  wire logic [4:0]          slot_out_wordlength,       // Slot output wordlength, 16 to 24
  input  wire logic                rx_valid,                  // Received sample strobe, one cycle
  input  wire sdc_pkg::sdc_stereo_t rx_sample,                // Received stereo sample
  input  wire logic                rx_emphasis,               // Received stream carries emphasis
  input  wire sdc_pkg::sdc_stereo_t analog_in,                // Analog inputs 13 and 14
  input  wire logic                swap_sel,                  // Exchange input routings
  input  wire logic                cascade_on,                // Cascade gate on
  input  wire sdc_pkg::sdc_stage_t cascade_stage,             // Position in a cascade chain
  output logic                     sample_tick,               // Sample clock pulse
  output logic                     tx_valid,                  // Transmit sample strobe
  output sdc_pkg::sdc_stereo_t     tx_sample,                 // Dithered stereo output sample
  output sdc_pkg::sdc_stereo_t     slot_out,                  // Dithered slot output pair
  output sdc_pkg::sdc_stereo_t     ch_pair_out,               // Feed of channels 13 and 14
  output sdc_pkg::sdc_stereo_t     cascade_pre,               // Cascade tap ahead of the gate
  output sdc_pkg::sdc_stereo_t     stereo_bus_out,            // Cascade tap after the gate
  output logic                     locking,                   // Acquiring the external clock
  output logic                     lock_lost,                 // External clock has vanished
  output logic                     locked                     // Running on a good clock
);
  import sdc_pkg::*;

  // Wordlength reduction with dither rounding of the kept LSB
  function automatic logic signed [SAMPLE_W-1:0] dither_round(
    input logic signed [SAMPLE_W-1:0] s,
    input logic [4:0]                 wl,
    input logic [SAMPLE_W-1:0]        rnd
  );
    logic [4:0]                 drop;
    logic [SAMPLE_W-1:0]        mask;
    logic signed [SAMPLE_W-1:0] kept;
    logic signed [SAMPLE_W:0]   up;
    drop = (wl >= WL_MAX) ? 5'h00 : (wl < WL_MIN) ? (WL_MAX - WL_MIN) : (WL_MAX - wl);
    mask = ~({SAMPLE_W{1'b1}} << drop);
    kept = s & $signed(~mask);
    // Kept part plus one output step; unsigned sum wraps like two's complement
    up   = {kept[SAMPLE_W-1], kept} + {1'b0, mask} + {{SAMPLE_W{1'b0}}, 1'b1};
    // Round up when the discarded part beats the random draw; clamp at positive full scale
    if ((s & mask) > (rnd & mask) && up[SAMPLE_W] == up[SAMPLE_W-1]) begin
      dither_round = up[SAMPLE_W-1:0];
    end else begin
      dither_round = kept;
    end
  endfunction

  // First-order shelf that undoes 50/15 us emphasis, Q15 coefficients, saturating
  function automatic logic signed [SAMPLE_W-1:0] deemph(
    input logic signed [SAMPLE_W-1:0] x,
    input logic signed [SAMPLE_W-1:0] x1,
    input logic signed [SAMPLE_W-1:0] y1
  );
    logic signed [SAMPLE_W+17:0] acc;
    acc = x * DE_B0 + x1 * DE_B1 + y1 * DE_A1;
    acc = acc >>> 15;
    if (acc > (SAMPLE_W+18)'(2**(SAMPLE_W-1) - 1)) begin
      deemph = {1'b0, {(SAMPLE_W-1){1'b1}}};
    end else if (acc < -(SAMPLE_W+18)'(2**(SAMPLE_W-1))) begin
      deemph = {1'b1, {(SAMPLE_W-1){1'b0}}};
    end else begin
      deemph = acc[SAMPLE_W-1:0];
    end
  endfunction

  // Sample clock and lock tracking state
  logic [15:0]  div_reg, div_next;                            // Internal rate divider
  logic [15:0]  gap_reg, gap_next;                            // Cycles since last received sample
  logic [3:0]   good_reg, good_next;                          // Clean samples while acquiring
  sdc_lock_t    lk_reg, lk_next;                              // Lock state
  logic         tick;                                         // Selected sample clock pulse
  logic         timeout;                                      // Received stream went silent
  // Receive path state
  sdc_stereo_t  rx_hold_reg, rx_hold_next;                    // Latest received sample, de-emphasised when flagged
  sdc_stereo_t  x1_reg, x1_next;                              // Previous raw received sample
  // Output side state
  logic [23:0]  lfsr_reg, lfsr_next;                          // Dither random source
  sdc_stereo_t  tx_reg, tx_next, slot_reg, slot_next;         // Dithered outputs
  sdc_stereo_t  ch_reg, ch_next, pre_reg, pre_next;           // Routed inputs
  sdc_stereo_t  bus_reg, bus_next;                            // Gated cascade signal
  logic         tick_reg, locking_reg, lost_reg, locked_reg;  // Status flags
  sdc_stereo_t  dly_out;                                      // Delayed own inputs
  logic [4:0]   dly_tap;                                      // Delay for this stage
  logic         swap_eff, gate_eff;                           // Routing after cascade override

  // Own inputs delayed to line up with the upstream mix
  sdc_sample_delay #(.DEPTH(DLY_DEPTH)) u_delay (
    .core_clk  (core_clk),
    .reset_n   (reset_n),
    .sample_en (tick),
    .din       (analog_in),
    .tap       (dly_tap),
    .dout      (dly_out)
  );

  // Sample clock choice, silence detection and lock state
  always_comb begin
    div_next  = (div_reg >= 16'(INT_DIV - 1)) ? 16'h0000 : div_reg + 16'h0001;
    tick      = stereo_input_clock_source ? rx_valid : (div_reg >= 16'(INT_DIV - 1));
    // Silence count restarts on a new selection, so a stale count cannot flag loss at once
    gap_next  = (rx_valid || lk_reg == LK_INT) ? 16'h0000 :
                (gap_reg >= 16'(GAP_LIMIT - 1)) ? gap_reg : gap_reg + 16'h0001;
    timeout   = !rx_valid && gap_reg >= 16'(GAP_LIMIT - 1);
    lk_next   = lk_reg;
    good_next = good_reg;
    if (!stereo_input_clock_source) begin
      lk_next = LK_INT;
    end else begin
      case (lk_reg)
        LK_INT: begin
          lk_next   = LK_ACQ;
          good_next = 4'h0;
        end
        LK_ACQ: begin
          if (timeout) begin
            lk_next = LK_LOST;
          end else if (rx_valid) begin
            good_next = good_reg + 4'h1;
            if (good_reg == LOCK_STROBES - 4'h1) begin
              lk_next = LK_LOCKED;
            end
          end
        end
        LK_LOCKED: begin
          if (timeout) begin
            lk_next = LK_LOST;
          end
        end
        default: begin
          if (rx_valid) begin
            lk_next   = LK_ACQ;                               // Stream returned, reacquire
            good_next = 4'h0;
          end
        end
      endcase
    end
  end

  // Receive side: de-emphasis when flagged, else plain pass
  always_comb begin
    rx_hold_next = rx_hold_reg;
    x1_next      = x1_reg;
    if (rx_valid) begin
      x1_next = rx_sample;
      if (rx_emphasis) begin
        rx_hold_next.left  = deemph(rx_sample.left, x1_reg.left, rx_hold_reg.left);
        rx_hold_next.right = deemph(rx_sample.right, x1_reg.right, rx_hold_reg.right);
      end else begin
        rx_hold_next = rx_sample;                             // Filter state settles on clean input
      end
    end
  end

  // Routing, cascade gate and dithered outputs, all advanced once per sample
  always_comb begin
    case (cascade_stage)
      STG_LAST:   dly_tap = TAP_LAST;
      STG_MIDDLE: dly_tap = TAP_MIDDLE;
      default:    dly_tap = TAP_NONE;
    endcase
    // A chained unit must hear the upstream mix, whatever the panel says
    swap_eff  = (cascade_stage == STG_SOLO) ? swap_sel : 1'b0;
    gate_eff  = (cascade_stage == STG_SOLO) ? cascade_on : 1'b1;
    lfsr_next = lfsr_reg;
    tx_next   = tx_reg;
    slot_next = slot_reg;
    ch_next   = ch_reg;
    pre_next  = pre_reg;
    bus_next  = bus_reg;
    if (tick) begin
      lfsr_next = lfsr_reg[0] ? ((lfsr_reg >> 1) ^ LFSR_TAPS) : (lfsr_reg >> 1);
      tx_next.left    = dither_round(mix_in.left, stereo_out_wordlength, lfsr_reg);
      tx_next.right   = dither_round(mix_in.right, stereo_out_wordlength, ~lfsr_reg);
      slot_next.left  = dither_round(slot_mix_in.left, slot_out_wordlength, lfsr_reg);
      slot_next.right = dither_round(slot_mix_in.right, slot_out_wordlength, ~lfsr_reg);
      ch_next  = swap_eff ? rx_hold_reg : dly_out;
      pre_next = swap_eff ? dly_out : rx_hold_reg;
      bus_next = gate_eff ? pre_next : '0;
    end
  end

  // All state registers
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      div_reg     <= 16'h0000;
      gap_reg     <= 16'h0000;
      good_reg    <= 4'h0;
      lk_reg      <= LK_INT;
      rx_hold_reg <= '0;
      x1_reg      <= '0;
      lfsr_reg    <= LFSR_SEED;
      tx_reg      <= '0;
      slot_reg    <= '0;
      ch_reg      <= '0;
      pre_reg     <= '0;
      bus_reg     <= '0;
      tick_reg    <= 1'b0;
      locking_reg <= 1'b0;
      lost_reg    <= 1'b0;
      locked_reg  <= 1'b1;
    end else begin
      div_reg     <= div_next;
      gap_reg     <= gap_next;
      good_reg    <= good_next;
      lk_reg      <= lk_next;
      rx_hold_reg <= rx_hold_next;
      x1_reg      <= x1_next;
      lfsr_reg    <= lfsr_next;
      tx_reg      <= tx_next;
      slot_reg    <= slot_next;
      ch_reg      <= ch_next;
      pre_reg     <= pre_next;
      bus_reg     <= bus_next;
      tick_reg    <= tick;
      locking_reg <= (lk_next == LK_ACQ);
      lost_reg    <= (lk_next == LK_LOST);
      locked_reg  <= (lk_next == LK_INT) || (lk_next == LK_LOCKED);
    end
  end

  assign sample_tick    = tick_reg;
  assign tx_valid       = tick_reg;
  assign tx_sample      = tx_reg;
  assign slot_out       = slot_reg;
  assign ch_pair_out    = ch_reg;
  assign cascade_pre    = pre_reg;
  assign stereo_bus_out = bus_reg;
  assign locking        = locking_reg;
  assign lock_lost      = lost_reg;
  assign locked         = locked_reg;

  tx_strobe_a: assert property (@(posedge core_clk) disable iff (!reset_n) tick |=> tx_valid)
    else $error("sample tick not followed by transmit strobe");
  wl16_lsb_a: assert property (@(posedge core_clk) disable iff (!reset_n)
    tx_valid && $past(stereo_out_wordlength) == 5'h10 |-> tx_sample.left[7:0] == 8'h00)
    else $error("16-bit output has live low bits");
  swap_route_a: assert property (@(posedge core_clk) disable iff (!reset_n)
    tick && swap_eff |=> cascade_pre == $past(dly_out) && ch_pair_out == $past(rx_hold_reg))
    else $error("swapped routing wrong");
  gate_off_a: assert property (@(posedge core_clk) disable iff (!reset_n)
    tick && !gate_eff |=> stereo_bus_out == '0 && cascade_pre == $past(pre_next))
    else $error("cascade gate off but signal passes");
  gate_on_a: assert property (@(posedge core_clk) disable iff (!reset_n)
    tick && gate_eff |=> stereo_bus_out == cascade_pre)
    else $error("post-gate tap differs from pre-gate tap");
  deemph_pass_a: assert property (@(posedge core_clk) disable iff (!reset_n)
    rx_valid && !rx_emphasis |=> rx_hold_reg == $past(rx_sample))
    else $error("unemphasised sample altered");
  cascade_bus_a: assert property (@(posedge core_clk) disable iff (!reset_n)
    tick && cascade_stage != STG_SOLO |=> stereo_bus_out == $past(rx_hold_reg))
    else $error("chained unit lost upstream mix");
  int_rate_a: assert property (@(posedge core_clk) disable iff (!reset_n)
    !stereo_input_clock_source && tick ##1 !stereo_input_clock_source |-> !tick [*8])
    else $error("internal sample clock too fast");
  acquire_a: assert property (@(posedge core_clk) disable iff (!reset_n)
    $rose(stereo_input_clock_source) |=> ##1 locking)
    else $error("new source not flagged as locking");
  lost_a: assert property (@(posedge core_clk) disable iff (!reset_n)
    stereo_input_clock_source && $past(stereo_input_clock_source) && timeout |-> ##[1:2] lock_lost)
    else $error("silent source not flagged as lost");
endmodule
`default_nettype wire

/* sim/sdc_far_end.sv */
// Far-side source model: sends a stereo stream and counts frames of our output
`timescale 1ns/1ps
`default_nettype none
module sdc_far_end #(
  parameter int PERIOD = 20                  // Cycles between frames when free running
) (
  input  wire logic            core_clk,     // Shared sample-clock domain
  input  wire logic            run,          // Free-running frame source on
  input  wire logic            tx_valid,     // Strobe of the stream we record
  output logic                 rx_valid,     // Frame strobe toward the block
  output sdc_pkg::sdc_stereo_t rx_sample,    // Frame data
  output logic                 rx_emphasis,  // Emphasis flag of the frame
  output int                   tx_frames     // Frames recovered from our output
);
  import sdc_pkg::*;
  sdc_stereo_t pattern = '0;                 // Free-running frame content
  // One frame; lines are scrambled after it so stale data cannot pass
  task automatic send(input sdc_stereo_t s, input logic e);
    @(negedge core_clk);
    rx_valid = 1'b1;
    rx_sample = s;
    rx_emphasis = e;
    @(negedge core_clk);
    rx_valid = 1'b0;
    rx_sample = ~s;
    rx_emphasis = ~e;
  endtask
  // Frames timed from the block's own clock, as a clock master would send them
  // Run is looked at on the rising edge, clear of the bench's falling-edge writes
  initial begin
    rx_valid = 1'b0;
    rx_sample = '0;
    rx_emphasis = 1'b0;
    forever begin
      @(posedge core_clk);
      if (run) begin
        repeat (PERIOD - 2) @(negedge core_clk);
        pattern = pattern + 48'h000101_000202;
        send(pattern, 1'b0);
      end
    end
  end
  // Recorder side slaves to our output strobe
  initial tx_frames = 0;
  always @(posedge core_clk) if (tx_valid === 1'b1) tx_frames++;
endmodule
`default_nettype wire

/* sim/tb_sdc_stereo_io.sv */
// Self-checking bench for the stereo digital I/O and cascade block
`timescale 1ns/1ps
`default_nettype none
module tb_sdc_stereo_io;
  import sdc_pkg::*;
  localparam int DIV = 20;                                // Short sample period keeps the run brief
  localparam int GAP = 50;                                // Short lock-loss span
  localparam sdc_stereo_t CA = {24'h123456, 24'h0ABCDE}; // Analog pattern
  localparam sdc_stereo_t CB = {24'h054321, 24'h300000}; // Second analog pattern
  localparam sdc_stereo_t CR = {24'h111111, 24'h222222}; // Received pattern
  localparam sdc_stereo_t CX = {24'h100000, 24'h100000}; // Positive step
  localparam sdc_stereo_t CZ = '0;                        // Silence
  localparam logic [23:0] YH = 24'((64'd15070 * 64'h100000) >> 15); // First filtered step value
  typedef struct {int kind; sdc_stereo_t a; sdc_stereo_t b; sdc_stereo_t c;} sdc_note_t;
  sdc_note_t   notes[$];                                  // Expected results, oldest first
  sdc_note_t   n;                                         // Note under check
  int          failures = 0;                              // Mismatch count
  int          compares = 0;                              // Comparison count
  int          seed = 32748;                              // Random seed
  int          i, k, d, tx_frames;                        // Loop and scratch
  logic [63:0] rnd;                                       // Random word
  logic        core_clk, sw, gt;                          // Clock and routing expectations
  logic        reset_n = 1'b0, src_sel = 1'b0, swap_sel = 1'b0, cascade_on = 1'b1, run = 1'b0;
  logic [4:0]  st_wl = WL_MAX, sl_wl = WL_MAX;            // Output wordlengths
  sdc_stereo_t mix_in = '0, slot_mix_in = '0, analog_in = CA, va, vb;
  sdc_stage_t  cascade_stage = STG_LAST;                  // Chain position
  logic        rx_valid, rx_emphasis, sample_tick, tx_valid, locking, lock_lost, locked;
  sdc_stereo_t rx_sample, tx_sample, slot_out, ch_pair_out, cascade_pre, stereo_bus_out;

  sdc_stereo_io #(.INT_DIV(DIV), .GAP_LIMIT(GAP)) sdc_stereo_io_inst (
    .core_clk(core_clk), .reset_n(reset_n), .stereo_input_clock_source(src_sel),
    .mix_in(mix_in), .slot_mix_in(slot_mix_in), .stereo_out_wordlength(st_wl),
    .slot_out_wordlength(sl_wl), .rx_valid(rx_valid), .rx_sample(rx_sample),
    .rx_emphasis(rx_emphasis), .analog_in(analog_in), .swap_sel(swap_sel),
    .cascade_on(cascade_on), .cascade_stage(cascade_stage), .sample_tick(sample_tick),
    .tx_valid(tx_valid), .tx_sample(tx_sample), .slot_out(slot_out), .ch_pair_out(ch_pair_out),
    .cascade_pre(cascade_pre), .stereo_bus_out(stereo_bus_out), .locking(locking),
    .lock_lost(lock_lost), .locked(locked));
  sdc_far_end #(.PERIOD(DIV)) sdc_far_end_inst (.core_clk(core_clk), .run(run),
    .tx_valid(tx_valid), .rx_valid(rx_valid), .rx_sample(rx_sample),
    .rx_emphasis(rx_emphasis), .tx_frames(tx_frames));

  // 200 MHz clock
  initial begin
    core_clk = 1'b0;
    forever #2.5 core_clk = ~core_clk;
  end
  task automatic cmp_val(input logic [47:0] got, input logic [47:0] exp);
    compares++;
    if (got !== exp) begin
      failures++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // Accepts base or base plus one step; rounding may go either way
  task automatic cmp_near(input logic [23:0] got, input logic [23:0] base, input logic [23:0] step);
    logic [23:0] df;
    compares++;
    df = got - base;
    if (df !== 24'h000000 && df !== step) begin
      failures++;
      $display("wrong value at %0t: got %h expected %h", $time, got, base);
    end
  endtask
  task automatic note(input int kd, input sdc_stereo_t a, input sdc_stereo_t b, input sdc_stereo_t c);
    notes.push_back('{kd, a, b, c});
  endtask
  // Lands just after the edge that checks a result, well before the next sample
  task automatic sync;
    @(negedge core_clk iff tx_valid === 1'b1);
    @(negedge core_clk);
  endtask
  task automatic end_of_test;
    $display("compares %0d failures %0d", compares, failures);
    if (failures == 0 && compares > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  // Result watcher: one note per output sample
  always @(posedge core_clk) begin
    if (tx_valid === 1'b1 && notes.size() > 0) begin
      n = notes.pop_front();
      case (n.kind)
        0: begin
          cmp_val(tx_sample, n.a);
          cmp_near(slot_out.left, n.b.left & 24'hFFFFF0, 24'h000010);
          cmp_near(slot_out.right, n.b.right & 24'hFFFFF0, 24'h000010);
        end
        1: begin
          cmp_near(tx_sample.left, n.a.left & 24'hFFFF00, 24'h000100);
          cmp_near(tx_sample.right, n.a.right & 24'hFFFF00, 24'h000100);
          cmp_val(slot_out, n.b);
        end
        2: cmp_val(ch_pair_out, n.a);
        3: cmp_near(cascade_pre.left, n.a.left, 24'h000001);
        default: begin
          cmp_val(ch_pair_out, n.a);
          cmp_val(cascade_pre, n.b);
          cmp_val(stereo_bus_out, n.c);
        end
      endcase
    end
  end
  // Hang guard, far beyond the expected run length
  initial begin
    #100000;
    failures++;
    end_of_test;
  end
  initial begin
    repeat (8) @(posedge core_clk);
    @(negedge core_clk);
    reset_n = 1'b1;
    cmp_val(48'({locked, lock_lost}), 48'h2);
    @(posedge core_clk iff tx_valid === 1'b1);
    d = int'($time);
    @(posedge core_clk);
    @(posedge core_clk iff tx_valid === 1'b1);
    cmp_val(48'((int'($time) - d) / 5), 48'(DIV));
    sdc_far_end_inst.send(CR, 1'b0);
    // Chain delays, one step of the analog pair watched through the line
    for (k = 0; k < 2; k++) begin
      cascade_stage = k ? STG_MIDDLE : STG_LAST;
      d = k ? 28 : 14;
      va = k ? CB : CA;
      vb = k ? CA : CB;
      analog_in = va;
      repeat (32) sync;
      analog_in = vb;
      for (i = 0; i <= d + 2; i++) begin
        if (i == d - 1) note(2, va, CZ, CZ);
        if (i == d + 2) note(2, vb, CZ, CZ);
        sync;
      end
    end
    // Full and shortened wordlengths with random mixes
    cascade_stage = STG_SOLO;
    for (i = 0; i < 8; i++) begin
      rnd = {$random(seed), $random(seed)};
      mix_in = rnd[47:0];
      rnd = {$random(seed), $random(seed)};
      slot_mix_in = rnd[47:0];
      st_wl = (i < 4) ? WL_MAX : WL_MIN;
      sl_wl = (i < 4) ? 5'h14 : WL_MAX;
      note((i < 4) ? 0 : 1, mix_in, slot_mix_in, CZ);
      sync;
    end
    // Every swap and gate setting, then chain member overriding both
    for (i = 0; i < 6; i++) begin
      swap_sel = i[0];
      cascade_on = i[1];
      cascade_stage = (i > 3) ? STG_LAST : STG_SOLO;
      sw = swap_sel && (i < 4);
      gt = cascade_on || (i > 3);
      sync;
      note(5, sw ? CR : CA, sw ? CA : CR, gt ? (sw ? CA : CR) : CZ);
      sync;
    end
    // Plain step passes untouched, flagged step is de-emphasised
    cascade_stage = STG_SOLO;
    swap_sel = 1'b0;
    sdc_far_end_inst.send(CX, 1'b0);
    note(3, CX, CZ, CZ);
    sync;
    repeat (60) sdc_far_end_inst.send(CZ, 1'b1);
    sync;
    sdc_far_end_inst.send(CX, 1'b1);
    note(3, {YH - 24'h1, YH - 24'h1}, CZ, CZ);
    sync;
    // Follow the input clock, lose it, regain it, fall back to internal
    run = 1'b1;
    src_sel = 1'b1;
    repeat (3) @(negedge core_clk);
    cmp_val(48'(locking), 48'h1);
    repeat (8) @(posedge core_clk iff rx_valid === 1'b1);
    @(negedge core_clk);
    cmp_val(48'(sample_tick), 48'h1);
    @(negedge core_clk);
    cmp_val(48'({locked, locking}), 48'h2);
    run = 1'b0;
    repeat (DIV + GAP + 4) @(negedge core_clk);
    cmp_val(48'(lock_lost), 48'h1);
    run = 1'b1;
    @(posedge core_clk iff rx_valid === 1'b1);
    repeat (2) @(negedge core_clk);
    cmp_val(48'({lock_lost, locking}), 48'h1);
    src_sel = 1'b0;
    repeat (3) @(negedge core_clk);
    cmp_val(48'({locked, locking, lock_lost}), 48'h4);
    cmp_val(48'(tx_frames > 0), 48'h1);
    end_of_test;
  end
endmodule
`default_nettype wire
